// ### logic/fspc_ctrl.sv
// Flash self-programming controller with AHB-Lite register slave
`timescale 1ns/10ps
module fspc_ctrl #(
  parameter int WORD_BITS = 6,
  parameter logic [14:0] HALT_FIRST_WORD = 15'h1C00,
  parameter logic [15:0] BOOT_RESET_ADDR = 16'h1C00
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic global_int_en_i,
  output logic ready_irq_o,
  input wire logic boot_vector_select_fuse_i,
  output logic [15:0] reset_vector_o,
  input wire logic [7:0] fuse_low_i,
  input wire logic [7:0] lock_bits_i,
  output logic [14:0] flash_rd_addr_o,
  input wire logic [15:0] flash_rd_word_i,
  output fspc_pkg::fspc_flash_cmd_t flash_cmd_o,
  input wire logic flash_done_i,
  input wire logic [WORD_BITS-1:0] buf_rd_idx_i,
  output logic [15:0] buf_rd_data_o,
  output logic concurrent_read_block_o,
  output logic cpu_halt_o
);
  localparam int PAGE_WORDS = 1 << WORD_BITS;
  localparam logic [14:0] WORD_MASK = 15'(PAGE_WORDS - 1);

  fspc_pkg::fspc_state_t state_r;
  fspc_pkg::fspc_ahb_req_t req_r;
  fspc_pkg::fspc_flash_cmd_t flash_cmd_r;
  logic [2:0] win_r;
  logic [4:0] cmd_r;
  logic ready_interrupt_enable_r;
  logic concurrent_section_busy_r;
  logic halt_op_r;
  logic [14:0] page_r;
  logic [15:0] ptr_r;
  logic [15:0] opnd_r;
  logic [31:0] hrdata_r;
  logic [15:0] buf_mem [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] buf_valid_r;
  logic [15:0] buf_rd_r;
  logic fz1_r;
  logic fz2_r;
  logic fz3_r;
  logic [15:0] vec_r;
  logic addr_ok;
  logic csr_wr;
  logic store_go;
  logic lock_read_go;
  logic ld_rd;
  logic [WORD_BITS-1:0] word_idx;
  logic [7:0] load_byte;

  function automatic logic cmd_legal(input logic [4:0] v);
    cmd_legal = (v == fspc_pkg::CMD_REEN) || (v == fspc_pkg::CMD_LOCK) || (v == fspc_pkg::CMD_WRITE) ||
                (v == fspc_pkg::CMD_ERASE) || (v == fspc_pkg::CMD_FILL);
  endfunction : cmd_legal

  function automatic logic in_halting(input logic [14:0] word_addr);
    in_halting = word_addr >= HALT_FIRST_WORD;
  endfunction : in_halting

  // Bus decode; full-word accesses only, upper address bits alias
  assign addr_ok = hsel_i && htrans_i[fspc_pkg::HTRANS_ACTIVE_BIT] && hready_i;
  assign ld_rd = addr_ok && !hwrite_i && (haddr_i[7:0] == fspc_pkg::LOAD_OFF);
  assign csr_wr = req_r.wr && (req_r.off == fspc_pkg::CSR_OFF);
  assign store_go = req_r.wr && (req_r.off == fspc_pkg::STORE_OFF) && (state_r == fspc_pkg::FSPC_ARMED);
  assign lock_read_go = ld_rd && (state_r == fspc_pkg::FSPC_ARMED) && (cmd_r == fspc_pkg::CMD_LOCK) &&
                        (win_r > (fspc_pkg::STORE_WINDOW - fspc_pkg::LOAD_WINDOW));
  assign word_idx = ptr_r[WORD_BITS:1];

  assign hreadyout_o = 1'b1;
  assign hresp_o = fspc_pkg::HRESP_OKAY;
  assign hrdata_o = hrdata_r;
  assign flash_cmd_o = flash_cmd_r;
  assign buf_rd_data_o = buf_rd_r;
  assign reset_vector_o = vec_r;
  assign flash_rd_addr_o = ptr_r[15:1];
  assign concurrent_read_block_o = concurrent_section_busy_r;
  assign cpu_halt_o = (state_r == fspc_pkg::FSPC_BUSY) && halt_op_r;
  assign ready_irq_o = ready_interrupt_enable_r && global_int_en_i &&
                       (state_r == fspc_pkg::FSPC_IDLE);

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      req_r <= '0;
    end
    else
    begin
      req_r.wr <= addr_ok && hwrite_i;
      req_r.rd <= addr_ok && !hwrite_i;
      req_r.off <= haddr_i[7:0];
    end
  end

  // Loads read through the pointer byte by byte
  always_comb
  begin
    load_byte = ptr_r[0] ? flash_rd_word_i[15:8] : flash_rd_word_i[7:0];
    if (lock_read_go)
    begin
      load_byte = ptr_r[0] ? lock_bits_i : fuse_low_i;
    end
    else if (concurrent_section_busy_r && !in_halting(ptr_r[15:1]))
    begin
      load_byte = fspc_pkg::BLANK_BYTE;
    end
  end

  // Read data captured in the address phase, so a load acts once
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      hrdata_r <= fspc_pkg::ZERO_WORD;
    end
    else if (addr_ok && !hwrite_i)
    begin
      unique case (haddr_i[7:0])
        fspc_pkg::CSR_OFF: hrdata_r <= {24'h000000, ready_interrupt_enable_r, concurrent_section_busy_r,
                                        1'b0, cmd_r};
        fspc_pkg::PTR_OFF: hrdata_r <= {16'h0000, ptr_r};
        fspc_pkg::OPND_OFF: hrdata_r <= {16'h0000, opnd_r};
        fspc_pkg::LOAD_OFF: hrdata_r <= {24'h000000, load_byte};
        default: hrdata_r <= fspc_pkg::ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      ptr_r <= 16'h0000;
      opnd_r <= 16'h0000;
      ready_interrupt_enable_r <= fspc_pkg::CSR_RESET[fspc_pkg::IE_BIT];
    end
    else if (req_r.wr)
    begin
      if (req_r.off == fspc_pkg::PTR_OFF)
      begin
        ptr_r <= hwdata_i[15:0];
      end
      if (req_r.off == fspc_pkg::OPND_OFF)
      begin
        opnd_r <= hwdata_i[15:0];
      end
      if (req_r.off == fspc_pkg::CSR_OFF)
      begin
        ready_interrupt_enable_r <= hwdata_i[fspc_pkg::IE_BIT];
      end
    end
  end

  // Command sequencer: arm window, then store, load or timeout
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      state_r <= fspc_pkg::FSPC_IDLE;
      win_r <= 3'h0;
      cmd_r <= fspc_pkg::CMD_NONE;
    end
    else
    begin
      unique case (state_r)
        fspc_pkg::FSPC_BUSY:
        begin
          // Command and store writes are refused here, enable stays high
          if (flash_done_i)
          begin
            state_r <= fspc_pkg::FSPC_IDLE;
            cmd_r <= fspc_pkg::CMD_NONE;
          end
        end
        fspc_pkg::FSPC_IDLE, fspc_pkg::FSPC_ARMED:
        begin
          if (csr_wr && cmd_legal(hwdata_i[fspc_pkg::CMD_W-1:0]))
          begin
            state_r <= fspc_pkg::FSPC_ARMED;
            win_r <= fspc_pkg::STORE_WINDOW;
            cmd_r <= hwdata_i[fspc_pkg::CMD_W-1:0];
          end
          else if (store_go)
          begin
            if (cmd_r == fspc_pkg::CMD_ERASE || cmd_r == fspc_pkg::CMD_WRITE)
            begin
              state_r <= fspc_pkg::FSPC_BUSY;
            end
            else
            begin
              state_r <= fspc_pkg::FSPC_IDLE;
              cmd_r <= fspc_pkg::CMD_NONE;
            end
          end
          else if (lock_read_go || (state_r == fspc_pkg::FSPC_ARMED && win_r == fspc_pkg::WIN_LAST))
          begin
            state_r <= fspc_pkg::FSPC_IDLE;
            cmd_r <= fspc_pkg::CMD_NONE;
          end
          else if (state_r == fspc_pkg::FSPC_ARMED)
          begin
            win_r <= win_r - 3'h1;
          end
        end
        default:
        begin
          state_r <= fspc_pkg::FSPC_IDLE;
          cmd_r <= fspc_pkg::CMD_NONE;
        end
      endcase
    end
  end

  // Operation start: latch page and issue one-cycle flash command
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      flash_cmd_r <= '0;
      page_r <= 15'h0000;
      halt_op_r <= 1'b0;
    end
    else
    begin
      flash_cmd_r.erase <= 1'b0;
      flash_cmd_r.write <= 1'b0;
      flash_cmd_r.lock <= 1'b0;
      if (store_go && (cmd_r == fspc_pkg::CMD_ERASE || cmd_r == fspc_pkg::CMD_WRITE))
      begin
        page_r <= ptr_r[15:1] & ~WORD_MASK;
        halt_op_r <= in_halting(ptr_r[15:1]);
        flash_cmd_r.erase <= cmd_r == fspc_pkg::CMD_ERASE;
        flash_cmd_r.write <= cmd_r == fspc_pkg::CMD_WRITE;
        flash_cmd_r.word_addr <= ptr_r[15:1] & ~WORD_MASK;
      end
      if (store_go && cmd_r == fspc_pkg::CMD_LOCK)
      begin
        flash_cmd_r.lock <= 1'b1;
        flash_cmd_r.lock_data <= opnd_r[7:0];
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      concurrent_section_busy_r <= fspc_pkg::CSR_RESET[fspc_pkg::BUSY_BIT];
    end
    else if (store_go && (cmd_r == fspc_pkg::CMD_ERASE || cmd_r == fspc_pkg::CMD_WRITE))
    begin
      if (!in_halting(ptr_r[15:1]))
      begin
        concurrent_section_busy_r <= 1'b1;
      end
    end
    else if (store_go && (cmd_r == fspc_pkg::CMD_REEN || cmd_r == fspc_pkg::CMD_FILL))
    begin
      concurrent_section_busy_r <= 1'b0;
    end
  end

  // Temporary page buffer; a cleared word reads blank
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      buf_valid_r <= '0;
    end
    else if ((state_r == fspc_pkg::FSPC_BUSY && cmd_r == fspc_pkg::CMD_WRITE && flash_done_i) ||
             (state_r != fspc_pkg::FSPC_BUSY && csr_wr && hwdata_i[fspc_pkg::CMD_W-1:0] == fspc_pkg::CMD_REEN))
    begin
      buf_valid_r <= '0;
    end
    else if (store_go && cmd_r == fspc_pkg::CMD_FILL)
    begin
      buf_valid_r[word_idx] <= 1'b1;
    end
  end

  // A word already loaded keeps its first value until cleared
  always_ff @(posedge mclk_i)
  begin
    if (store_go && cmd_r == fspc_pkg::CMD_FILL && !buf_valid_r[word_idx])
    begin
      buf_mem[word_idx] <= opnd_r;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      buf_rd_r <= fspc_pkg::BLANK_WORD;
    end
    else
    begin
      buf_rd_r <= buf_valid_r[buf_rd_idx_i] ? buf_mem[buf_rd_idx_i] : fspc_pkg::BLANK_WORD;
    end
  end

  // Fuse is read only; nothing here drives it
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      fz1_r <= 1'b1;
      fz2_r <= 1'b1;
      fz3_r <= 1'b1;
      vec_r <= fspc_pkg::APP_RESET_ADDR;
    end
    else
    begin
      fz1_r <= boot_vector_select_fuse_i;
      fz2_r <= fz1_r;
      fz3_r <= fz2_r;
      if (fz2_r == fz3_r)
      begin
        vec_r <= fz3_r ? fspc_pkg::APP_RESET_ADDR : BOOT_RESET_ADDR;
      end
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  irq_on_idle_a: assert property (ready_interrupt_enable_r && global_int_en_i && !cmd_r[0] |-> ready_irq_o)
    else $error("ready interrupt missing while enable bit clear");
  irq_armed_quiet_a: assert property (cmd_r[0] |-> !ready_irq_o)
    else $error("ready interrupt while command enabled");
  reserved_zero_a: assert property (req_r.rd && req_r.off == fspc_pkg::CSR_OFF
    |-> !hrdata_o[fspc_pkg::RES_BIT]) else $error("reserved bit read as one");
  busy_block_a: assert property (store_go && cmd_r == fspc_pkg::CMD_ERASE && !in_halting(ptr_r[15:1])
    |=> concurrent_read_block_o && state_r == fspc_pkg::FSPC_BUSY)
    else $error("busy flag not set by concurrent erase");
  window_expire_a: assert property ((state_r == fspc_pkg::FSPC_ARMED && win_r == fspc_pkg::STORE_WINDOW)
    ##0 (!req_r.wr && !ld_rd)[*4] |=> state_r == fspc_pkg::FSPC_IDLE && cmd_r == fspc_pkg::CMD_NONE)
    else $error("command window did not expire after four cycles");
  enable_held_a: assert property (state_r == fspc_pkg::FSPC_BUSY && !flash_done_i
    |=> state_r == fspc_pkg::FSPC_BUSY && cmd_r == $past(cmd_r))
    else $error("enable dropped before operation done");
  halt_erase_a: assert property (flash_cmd_r.erase && in_halting(flash_cmd_r.word_addr) |-> cpu_halt_o)
    else $error("cpu not halted on halting-section erase");
  buf_clear_a: assert property (state_r == fspc_pkg::FSPC_BUSY && cmd_r == fspc_pkg::CMD_WRITE && flash_done_i
    |=> buf_valid_r == '0)
    else $error("buffer not cleared after page write");
  page_latched_a: assert property (state_r == fspc_pkg::FSPC_BUSY ##1 state_r == fspc_pkg::FSPC_BUSY
    |-> $stable(page_r))
    else $error("page address changed during operation");
  lock_read_sel_a: assert property (lock_read_go && ptr_r[0] |=> hrdata_o[7:0] == $past(lock_bits_i))
    else $error("lock bits not returned by armed load");
  bad_cmd_a: assert property (csr_wr && state_r == fspc_pkg::FSPC_IDLE &&
    !cmd_legal(hwdata_i[fspc_pkg::CMD_W-1:0]) |=> state_r == fspc_pkg::FSPC_IDLE)
    else $error("illegal command pattern took effect");

  fill_cov_c: cover property (store_go && cmd_r == fspc_pkg::CMD_FILL);
  erase_done_c: cover property (state_r == fspc_pkg::FSPC_BUSY && cmd_r == fspc_pkg::CMD_ERASE && flash_done_i);
  lock_read_c: cover property (lock_read_go);
  reenable_c: cover property (store_go && cmd_r == fspc_pkg::CMD_REEN);
endmodule : fspc_ctrl

// ### logic/fspc_pkg.sv
// Constants, types and register map of the flash self-programming controller
package fspc_pkg;
  localparam logic [7:0] CSR_OFF = 8'h00;
  localparam logic [7:0] PTR_OFF = 8'h04;
  localparam logic [7:0] OPND_OFF = 8'h08;
  localparam logic [7:0] STORE_OFF = 8'h0C;
  localparam logic [7:0] LOAD_OFF = 8'h10;
  localparam int IE_BIT = 7;
  localparam int BUSY_BIT = 6;
  localparam int RES_BIT = 5;
  localparam int CMD_W = 5;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [4:0] CMD_NONE = 5'h00;
  localparam logic [4:0] CMD_REEN = 5'h11;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_FILL = 5'h01;
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  localparam logic [2:0] LOAD_WINDOW = 3'h3;
  localparam logic [2:0] WIN_LAST = 3'h1;
  localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
  localparam logic [15:0] BLANK_WORD = 16'hFFFF;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    FSPC_IDLE = 2'b00,
    FSPC_ARMED = 2'b01,
    FSPC_BUSY = 2'b10
  } fspc_state_t;

  typedef struct packed {
    logic erase;
    logic write;
    logic lock;
    logic [14:0] word_addr;
    logic [7:0] lock_data;
  } fspc_flash_cmd_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] off;
  } fspc_ahb_req_t;
endpackage : fspc_pkg

// ### verif/fspc_flash_model.sv
// Flash macro stand-in: finishes erase and write after a set delay
`timescale 1ns/10ps
module fspc_flash_model (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire fspc_pkg::fspc_flash_cmd_t cmd_i,
  input wire logic [7:0] delay_i,
  input wire logic [14:0] rd_addr_i,
  output logic [15:0] rd_word_o,
  output logic done_o,
  output logic [14:0] last_addr_o,
  output logic [7:0] last_lock_o
);
  logic [7:0] cnt_r;
  // High and low bytes differ so a wrong byte select shows
  assign rd_word_o = {8'hA5, rd_addr_i[7:0]};
  always_ff @(posedge mclk_i)
  begin
    done_o <= 1'b0;
    if (srst_i)
    begin
      cnt_r <= 8'h00;
      last_addr_o <= 15'h0000;
      last_lock_o <= 8'h00;
    end
    else if (cmd_i.erase | cmd_i.write)
    begin
      cnt_r <= delay_i;
      last_addr_o <= cmd_i.word_addr;
    end
    else if (cnt_r == 8'h01)
    begin
      done_o <= 1'b1;
      cnt_r <= 8'h00;
    end
    else if (cnt_r != 8'h00)
      cnt_r <= cnt_r - 8'h01;
    if (!srst_i && cmd_i.lock)
      last_lock_o <= cmd_i.lock_data;
  end
endmodule : fspc_flash_model

// ### verif/tb_top.sv
// Self-checking bench for the flash self-programming controller
`timescale 1ns/10ps
module tb_top;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic gie = 1'b0;
  logic fuse = 1'b1;
  logic [5:0] idx = 6'h00;
  logic [7:0] dly = 8'h01;
  logic hrdy, hresp, irq, done, blk, halt;
  logic [31:0] hrdata, q;
  logic [15:0] rvec, rword, bdata;
  logic [14:0] raddr, laddr;
  logic [7:0] llock;
  logic [7:0] bad [5] = '{8'h82, 8'h87, 8'h93, 8'h99, 8'h8F};
  fspc_pkg::fspc_flash_cmd_t cmd;
  int error_cnt = 0;
  int checked = 0;

  always #10 mclk_i = ~mclk_i;

  fspc_ctrl DUT (.mclk_i(mclk_i), .srst_i(srst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy),
    .hresp_o(hresp), .hrdata_o(hrdata), .global_int_en_i(gie), .ready_irq_o(irq),
    .boot_vector_select_fuse_i(fuse), .reset_vector_o(rvec), .fuse_low_i(8'h5A), .lock_bits_i(8'h3C),
    .flash_rd_addr_o(raddr), .flash_rd_word_i(rword), .flash_cmd_o(cmd), .flash_done_i(done),
    .buf_rd_idx_i(idx), .buf_rd_data_o(bdata), .concurrent_read_block_o(blk), .cpu_halt_o(halt));

  fspc_flash_model flash (.mclk_i(mclk_i), .srst_i(srst_i), .cmd_i(cmd), .delay_i(dly), .rd_addr_i(raddr),
    .rd_word_o(rword), .done_o(done), .last_addr_o(laddr), .last_lock_o(llock));

  task automatic results();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Bounded wait for hready at a rising edge
  task automatic edge_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (hrdy !== 1'b1 && n < 20);
    if (hrdy !== 1'b1)
    begin
      error_cnt++;
      results();
    end
  endtask : edge_rdy

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    edge_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    edge_rdy();
    q = hrdata;
    chk({31'h0, hresp}, {31'h0, fspc_pkg::HRESP_OKAY});
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask : rd

  // Arm a command and issue the store right behind it
  task automatic cmd_go(input logic [7:0] c);
    wr(fspc_pkg::CSR_OFF, {24'h00_0000, c});
    wr(fspc_pkg::STORE_OFF, 32'h0000_0000);
  endtask : cmd_go

  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      ahb(1'b0, fspc_pkg::CSR_OFF, 32'h0000_0000);
      n++;
    end
    while (q[0] !== 1'b0 && n < 40);
    if (q[0] !== 1'b0)
    begin
      error_cnt++;
      results();
    end
  endtask : wait_idle

  // Buffer read port answers one cycle after the index
  task automatic bufchk(input logic [5:0] i, input logic [15:0] exp);
    idx <= i;
    @(posedge mclk_i);
    @(posedge mclk_i);
    chk({16'h0000, bdata}, {16'h0000, exp});
  endtask : bufchk

  initial
  begin
    repeat (8) @(posedge mclk_i);
    srst_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    chk({16'h0000, rvec}, 32'h0000_0000);
    rd(fspc_pkg::CSR_OFF, 32'h0000_0000);
    fuse <= 1'b0;
    repeat (5) @(posedge mclk_i);
    chk({16'h0000, rvec}, 32'h0000_1C00);
    wr(fspc_pkg::CSR_OFF, 32'h0000_00FF);
    rd(fspc_pkg::CSR_OFF, 32'h0000_0080);
    chk({31'h0, irq}, 32'h0000_0000);
    gie <= 1'b1;
    @(posedge mclk_i);
    @(posedge mclk_i);
    chk({31'h0, irq}, 32'h0000_0001);
    foreach (bad[i])
    begin
      wr(fspc_pkg::CSR_OFF, {24'h00_0000, bad[i]});
      rd(fspc_pkg::CSR_OFF, 32'h0000_0080);
    end
    wr(fspc_pkg::PTR_OFF, 32'h0000_0004);
    wr(fspc_pkg::OPND_OFF, 32'h0000_BEEF);
    cmd_go(8'h81);
    wr(fspc_pkg::PTR_OFF, 32'h0000_0003);
    wr(fspc_pkg::OPND_OFF, 32'h0000_1234);
    cmd_go(8'h81);
    rd(fspc_pkg::CSR_OFF, 32'h0000_0080);
    bufchk(6'h02, 16'hBEEF);
    bufchk(6'h01, 16'h1234);
    wr(fspc_pkg::CSR_OFF, 32'h0000_0081);
    rd(fspc_pkg::CSR_OFF, 32'h0000_0081);
    repeat (4) @(posedge mclk_i);
    rd(fspc_pkg::CSR_OFF, 32'h0000_0080);
    wr(fspc_pkg::PTR_OFF, 32'h0000_0000);
    wr(fspc_pkg::STORE_OFF, 32'h0000_0000);
    bufchk(6'h00, 16'hFFFF);
    dly <= 8'h28;
    wr(fspc_pkg::PTR_OFF, 32'h0000_0080);
    cmd_go(8'h83);
    wr(fspc_pkg::PTR_OFF, 32'h0000_0006);
    rd(fspc_pkg::CSR_OFF, 32'h0000_00C3);
    chk({31'h0, blk}, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    rd(fspc_pkg::LOAD_OFF, 32'h0000_00FF);
    wr(fspc_pkg::CSR_OFF, 32'h0000_0091);
    rd(fspc_pkg::CSR_OFF, 32'h0000_00C3);
    wait_idle();
    chk({17'h0, laddr}, 32'h0000_0040);
    rd(fspc_pkg::CSR_OFF, 32'h0000_00C0);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(fspc_pkg::OPND_OFF, 32'h0000_7777);
    cmd_go(8'h81);
    rd(fspc_pkg::CSR_OFF, 32'h0000_0080);
    bufchk(6'h03, 16'h7777);
    dly <= 8'h01;
    cmd_go(8'h83);
    wait_idle();
    rd(fspc_pkg::CSR_OFF, 32'h0000_00C0);
    cmd_go(8'h91);
    rd(fspc_pkg::CSR_OFF, 32'h0000_0080);
    chk({31'h0, blk}, 32'h0000_0000);
    bufchk(6'h02, 16'hFFFF);
    rd(fspc_pkg::LOAD_OFF, 32'h0000_0003);
    wr(fspc_pkg::PTR_OFF, 32'h0000_0007);
    rd(fspc_pkg::LOAD_OFF, 32'h0000_00A5);
    dly <= 8'h08;
    wr(fspc_pkg::PTR_OFF, 32'h0000_3800);
    cmd_go(8'h83);
    @(posedge mclk_i);
    chk({31'h0, halt}, 32'h0000_0001);
    wait_idle();
    wr(fspc_pkg::OPND_OFF, 32'h0000_ABCD);
    cmd_go(8'h81);
    bufchk(6'h00, 16'hABCD);
    cmd_go(8'h85);
    @(posedge mclk_i);
    chk({31'h0, halt}, 32'h0000_0001);
    rd(fspc_pkg::CSR_OFF, 32'h0000_0085);
    wait_idle();
    chk({31'h0, halt}, 32'h0000_0000);
    chk({17'h0, laddr}, 32'h0000_1C00);
    bufchk(6'h00, 16'hFFFF);
    wr(fspc_pkg::OPND_OFF, 32'h0000_12C3);
    cmd_go(8'h89);
    repeat (2) @(posedge mclk_i);
    chk({24'h0, llock}, 32'h0000_00C3);
    rd(fspc_pkg::CSR_OFF, 32'h0000_0080);
    wr(fspc_pkg::PTR_OFF, 32'h0000_0001);
    wr(fspc_pkg::CSR_OFF, 32'h0000_0089);
    rd(fspc_pkg::LOAD_OFF, 32'h0000_003C);
    wr(fspc_pkg::PTR_OFF, 32'h0000_0000);
    wr(fspc_pkg::CSR_OFF, 32'h0000_0089);
    rd(fspc_pkg::LOAD_OFF, 32'h0000_005A);
    rd(fspc_pkg::CSR_OFF, 32'h0000_0080);
    wr(fspc_pkg::PTR_OFF, 32'h0000_0008);
    cmd_go(8'h81);
    srst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(posedge mclk_i);
    bufchk(6'h04, 16'hFFFF);
    rd(fspc_pkg::CSR_OFF, 32'h0000_0000);
    results();
  end
endmodule : tb_top
